// file: src/pwm_host_pkg.sv
// Function
// - Select polarity before pins become outputs; never change it while driving.
// - Enable module and let one full PWM cycle pass before pins drive.
// - First set all PWM pins to input, then load the period register.
// - Pick output configuration with the two top mode bits.
// - Load duty low byte plus control bits 5:4 for the duty.
// - For half-bridge, load deadband_count into delay bits 6:0.
// - Clear status, configure source, then wait until no shutdown condition.
// - Program source and pair states, then set status so outputs start held.
// - For auto restart, set restart_enable, delay bit 7, during setup.
// - Clear timer flag, load prescale bits 1:0, then set timer_on bit 2.
// - Wait timer flag, make pins outputs, then clear status to start modulation.
package pwm_host_pkg;

	// ********************************************************************
	// Device register indices (device side port)
	// ********************************************************************
	localparam logic [2:0] DEV_TIMER_COUNT   = 3'h0;
	localparam logic [2:0] DEV_TIMER_CONTROL = 3'h1;
	localparam logic [2:0] DEV_TIMER_PERIOD  = 3'h2;
	localparam logic [2:0] DEV_DUTY_LOW      = 3'h3;
	localparam logic [2:0] DEV_DUTY_HIGH     = 3'h4;
	localparam logic [2:0] DEV_MODE_CONTROL  = 3'h5;
	localparam logic [2:0] DEV_SHUTDOWN_CTRL = 3'h6;
	localparam logic [2:0] DEV_DEADBAND_RST  = 3'h7;

	// ********************************************************************
	// Device field positions
	// ********************************************************************
	localparam int        RESTART_BIT      = 7;
	localparam int        STATUS_BIT       = 7;
	localparam int        TIMER_ON_BIT     = 2;
	localparam logic [1:0] PWM_MODE_HI     = 2'h3;
	localparam logic [7:0] BYTE_ZERO       = 8'h00;

	// ********************************************************************
	// Own Wishbone register map, byte addresses
	// ********************************************************************
	localparam logic [3:0] ADR_CTRL   = 4'h0;
	localparam logic [3:0] ADR_CFG0   = 4'h4;
	localparam logic [3:0] ADR_CFG1   = 4'h8;
	localparam logic [3:0] ADR_STATUS = 4'hc;
	localparam int         CTRL_START = 0;
	localparam int         CTRL_STOP  = 1;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// Setup words as software sees them
	typedef struct packed {
		logic       unused;      // 31
		logic       restart;     // 30
		logic [6:0] deadband;    // 29:23
		logic       half_bridge; // 22
		logic [1:0] duty_bits;   // 21:20
		logic [1:0] polarity;    // 19:18
		logic [1:0] out_config;  // 17:16
		logic [7:0] duty_low;    // 15:8
		logic [7:0] period;      // 7:0
	} cfg0_t;

	typedef struct packed {
		logic [21:0] unused;     // 31:10
		logic        use_as;     // 9
		logic [1:0]  prescale;   // 8:7
		logic [1:0]  bd_state;   // 6:5
		logic [1:0]  ac_state;   // 4:3
		logic [2:0]  source;     // 2:0
	} cfg1_t;

	// One write to the device register port
	typedef struct packed {
		logic       we;
		logic [2:0] addr;
		logic [7:0] data;
	} dev_wr_t;

	// Gray coded along the setup path with use_as set
	typedef enum logic [4:0] {
		S_IDLE      = 5'h00,
		S_TRIS_IN   = 5'h01,
		S_PERIOD    = 5'h03,
		S_MODE      = 5'h02,
		S_DUTY      = 5'h06,
		S_AS_CLEAR  = 5'h07,
		S_AS_SRC    = 5'h05,
		S_AS_WAIT   = 5'h04,
		S_DEADBAND  = 5'h0c,
		S_AS_LOAD   = 5'h0d,
		S_RESTART   = 5'h0f,
		S_TMR_CLR   = 5'h0e,
		S_TMR_PRE   = 5'h0a,
		S_TMR_ON    = 5'h0b,
		S_WAIT_FLAG = 5'h09,
		S_TRIS_OUT  = 5'h08,
		S_RUN       = 5'h18,
		S_DONE      = 5'h19
	} state_t;

endpackage : pwm_host_pkg

// file: src/pwm_host.sv
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/100ps
module pwm_host #(
	parameter int ADR_W = 4
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               cyc_i,
	input  wire logic               stb_i,
	input  wire logic               we_i,
	input  wire logic [ADR_W-1:0]   adr_i,
	input  wire logic [3:0]         sel_i,
	input  wire logic [31:0]        dat_i,
	output logic      [31:0]        dat_o,
	output logic                    ack_o,
	output logic                    dev_we_o,
	output logic      [2:0]         dev_addr_o,
	output logic      [7:0]         dev_data_o,
	output logic                    timer_flag_clr_o,
	input  wire logic               timer_flag_i,
	input  wire logic               shutdown_active_i,
	output logic      [3:0]         pin_output_en_o
);

	// ********************************************************************
	// State
	// ********************************************************************
	typedef struct packed {
		pwm_host_pkg::state_t  st;
		pwm_host_pkg::cfg0_t   cfg0;
		pwm_host_pkg::cfg1_t   cfg1;
		pwm_host_pkg::dev_wr_t dev;
		logic                  flag_clr;
		logic [3:0]            pin_oe;
		logic                  done;
		logic                  ack;
		logic [31:0]           dat;
	} host_t;

	host_t q, d;

	// Byte lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = wr[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// One device register write
	function automatic pwm_host_pkg::dev_wr_t wr(input logic [2:0] a,
		input logic [7:0] v);
		pwm_host_pkg::dev_wr_t w;
		w.we   = 1'b1;
		w.addr = a;
		w.data = v;
		return w;
	endfunction : wr

	logic       req;
	logic [7:0] mode_byte;
	logic [7:0] as_byte;
	logic [7:0] del_byte;

	// Byte images built from the setup words
	always_comb begin
		mode_byte = {q.cfg0.out_config, q.cfg0.duty_bits,
			pwm_host_pkg::PWM_MODE_HI, q.cfg0.polarity};
		as_byte = {1'b0, q.cfg1.source, q.cfg1.ac_state,
			q.cfg1.bd_state};
		del_byte = {1'b0, q.cfg0.deadband};
	end

	// New request only when no answer is pending
	assign req = cyc_i && stb_i && !q.ack;

	// ********************************************************************
	// Bus slave and setup sequencer
	// ********************************************************************
	always_comb begin
		d          = q;
		d.dev.we   = 1'b0;
		d.flag_clr = 1'b0;
		d.ack      = req;
		if (req && !we_i) begin
			case (adr_i)
				pwm_host_pkg::ADR_CTRL: begin
					d.dat = {30'h0000_0000,
						q.done, q.st != pwm_host_pkg::S_IDLE};
				end
				pwm_host_pkg::ADR_CFG0: begin
					d.dat = q.cfg0;
				end
				pwm_host_pkg::ADR_CFG1: begin
					d.dat = q.cfg1;
				end
				pwm_host_pkg::ADR_STATUS: begin
					d.dat = {23'h00_0000, q.pin_oe, q.st};
				end
				default: begin
					d.dat = pwm_host_pkg::WORD_ZERO;
				end
			endcase
		end
		// Setup words frozen while a sequence runs, so polarity cannot
		// move under driving pins
		if (req && we_i && q.st == pwm_host_pkg::S_IDLE) begin
			if (adr_i == pwm_host_pkg::ADR_CFG0) begin
				d.cfg0 = merge(q.cfg0, dat_i, sel_i);
			end
			if (adr_i == pwm_host_pkg::ADR_CFG1) begin
				d.cfg1 = merge(q.cfg1, dat_i, sel_i);
			end
		end
		case (q.st)
			pwm_host_pkg::S_IDLE: begin
				if (req && we_i && adr_i == pwm_host_pkg::ADR_CTRL
						&& sel_i[0] && dat_i[pwm_host_pkg::CTRL_START]) begin
					d.done = 1'b0;
					d.st   = pwm_host_pkg::S_TRIS_IN;
				end
			end
			pwm_host_pkg::S_TRIS_IN: begin
				d.pin_oe = 4'h0;
				d.st     = pwm_host_pkg::S_PERIOD;
			end
			pwm_host_pkg::S_PERIOD: begin
				d.dev = wr(pwm_host_pkg::DEV_TIMER_PERIOD,
					q.cfg0.period);
				d.st  = pwm_host_pkg::S_MODE;
			end
			pwm_host_pkg::S_MODE: begin
				d.dev = wr(pwm_host_pkg::DEV_MODE_CONTROL,
					mode_byte);
				d.st  = pwm_host_pkg::S_DUTY;
			end
			pwm_host_pkg::S_DUTY: begin
				d.dev = wr(pwm_host_pkg::DEV_DUTY_LOW,
					q.cfg0.duty_low);
				d.st  = q.cfg1.use_as ? pwm_host_pkg::S_AS_CLEAR
					: pwm_host_pkg::S_DEADBAND;
			end
			pwm_host_pkg::S_AS_CLEAR: begin
				d.dev = wr(pwm_host_pkg::DEV_SHUTDOWN_CTRL,
					pwm_host_pkg::BYTE_ZERO);
				d.st  = pwm_host_pkg::S_AS_SRC;
			end
			pwm_host_pkg::S_AS_SRC: begin
				d.dev = wr(pwm_host_pkg::DEV_SHUTDOWN_CTRL,
					as_byte);
				d.st  = pwm_host_pkg::S_AS_WAIT;
			end
			pwm_host_pkg::S_AS_WAIT: begin
				// Waits for a run condition; no timeout by design. The
				// source write is still in flight on the first cycle, so
				// the device cannot report its cause until it lands
				if (!q.dev.we && !shutdown_active_i) begin
					d.st = pwm_host_pkg::S_DEADBAND;
				end
			end
			pwm_host_pkg::S_DEADBAND: begin
				if (q.cfg0.half_bridge) begin
					d.dev = wr(pwm_host_pkg::DEV_DEADBAND_RST,
						del_byte);
				end
				d.st = q.cfg1.use_as ? pwm_host_pkg::S_AS_LOAD
					: pwm_host_pkg::S_RESTART;
			end
			pwm_host_pkg::S_AS_LOAD: begin
				d.dev = wr(pwm_host_pkg::DEV_SHUTDOWN_CTRL, as_byte);
				d.dev.data[pwm_host_pkg::STATUS_BIT] = 1'b1;
				d.st  = pwm_host_pkg::S_RESTART;
			end
			pwm_host_pkg::S_RESTART: begin
				if (q.cfg0.restart) begin
					d.dev = wr(pwm_host_pkg::DEV_DEADBAND_RST, del_byte);
					d.dev.data[pwm_host_pkg::RESTART_BIT] = 1'b1;
				end
				d.st = pwm_host_pkg::S_TMR_CLR;
			end
			pwm_host_pkg::S_TMR_CLR: begin
				d.flag_clr = 1'b1;
				d.st       = pwm_host_pkg::S_TMR_PRE;
			end
			pwm_host_pkg::S_TMR_PRE: begin
				d.dev = wr(pwm_host_pkg::DEV_TIMER_CONTROL,
					{6'h00, q.cfg1.prescale});
				d.st  = pwm_host_pkg::S_TMR_ON;
			end
			pwm_host_pkg::S_TMR_ON: begin
				d.dev = wr(pwm_host_pkg::DEV_TIMER_CONTROL,
					{6'h00, q.cfg1.prescale});
				d.dev.data[pwm_host_pkg::TIMER_ON_BIT] = 1'b1;
				d.st  = pwm_host_pkg::S_WAIT_FLAG;
			end
			pwm_host_pkg::S_WAIT_FLAG: begin
				// Flag cleared two cycles before the timer-on write, so a set
				// flag means a fresh overflow
				if (timer_flag_i) begin
					d.st = pwm_host_pkg::S_TRIS_OUT;
				end
			end
			pwm_host_pkg::S_TRIS_OUT: begin
				d.pin_oe = 4'hf;
				d.st     = pwm_host_pkg::S_RUN;
			end
			pwm_host_pkg::S_RUN: begin
				d.dev = wr(pwm_host_pkg::DEV_SHUTDOWN_CTRL,
					as_byte);
				d.st  = pwm_host_pkg::S_DONE;
			end
			pwm_host_pkg::S_DONE: begin
				d.done = 1'b1;
				d.st   = pwm_host_pkg::S_IDLE;
			end
			default: begin
				d.st = pwm_host_pkg::S_IDLE;
			end
		endcase
		// Stop releases the pins first; the bridge's pulls hold it safe
		if (req && we_i && adr_i == pwm_host_pkg::ADR_CTRL && sel_i[0]
				&& dat_i[pwm_host_pkg::CTRL_STOP]) begin
			d.pin_oe = 4'h0;
			d.st     = pwm_host_pkg::S_IDLE;
		end
	end

	// Register the whole state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign ack_o            = q.ack;
	assign dat_o            = q.dat;
	assign dev_we_o         = q.dev.we;
	assign dev_addr_o       = q.dev.addr;
	assign dev_data_o       = q.dev.data;
	assign timer_flag_clr_o = q.flag_clr;
	assign pin_output_en_o  = q.pin_oe;

endmodule : pwm_host

// file: dv/pwm_host_assertions.sv
`timescale 1ns/100ps
module pwm_host_assertions (
	input logic       clk_i,
	input logic       rst_i,
	input logic       cyc_i,
	input logic       stb_i,
	input logic       ack_o,
	input logic       dev_we_o,
	input logic [2:0] dev_addr_o,
	input logic [7:0] dev_data_o,
	input logic       timer_flag_clr_o,
	input logic       timer_flag_i,
	input logic [3:0] pin_output_en_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic wr_tc;
	logic wr_as;
	logic oe_up;
	// Decoded device writes and pin enable, kept out of the properties for reading ease
	assign wr_tc = dev_we_o && dev_addr_o == pwm_host_pkg::DEV_TIMER_CONTROL;
	assign wr_as = dev_we_o && dev_addr_o == pwm_host_pkg::DEV_SHUTDOWN_CTRL;
	assign oe_up = |pin_output_en_o;
	chk_ack_one_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("ack is not a one cycle answer");
	chk_reset_quiet: assert property (disable iff (1'b0)
		rst_i |=> !ack_o && !dev_we_o && pin_output_en_o == 4'h0)
		else $error("outputs active after reset");
	chk_oe_after_flag: assert property ($rose(oe_up) |-> $past(timer_flag_i))
		else $error("pins driven before a full period");
	chk_status_clear_last: assert property ($rose(oe_up) |-> ##[0:2]
		(wr_as && !dev_data_o[7])) else $error("status not cleared after pins");
	chk_timer_on_order: assert property (wr_tc && dev_data_o[2] |->
		$past(wr_tc) && $past(dev_data_o) == (dev_data_o & 8'hfb))
		else $error("timer started without prescale load");
	chk_flag_clear_first: assert property (wr_tc && !dev_data_o[2] |->
		$past(timer_flag_clr_o)) else $error("flag not cleared first");
	chk_period_inputs: assert property (dev_we_o &&
		dev_addr_o == pwm_host_pkg::DEV_TIMER_PERIOD |-> pin_output_en_o == 4'h0)
		else $error("period loaded with pins driven");
	chk_mode_pwm: assert property (dev_we_o &&
		dev_addr_o == pwm_host_pkg::DEV_MODE_CONTROL |-> dev_data_o[3:2] == 2'h3)
		else $error("mode byte not a pwm mode");
	chk_clr_pulse: assert property (timer_flag_clr_o |=> !timer_flag_clr_o)
		else $error("flag clear longer than one cycle");
endmodule : pwm_host_assertions

// file: dv/pwm_dev_model.sv
`timescale 1ns/100ps
module pwm_dev_model (
	input  logic       clk_i,
	input  logic       rst_i,
	input  logic       dev_we_i,
	input  logic [2:0] dev_addr_i,
	input  logic [7:0] dev_data_i,
	input  logic       flag_clr_i,
	input  logic       fault_i,
	output logic       timer_flag_o,
	output logic       shutdown_active_o
);
	logic [7:0] regs_q [8];
	logic [7:0] tick_q;
	logic       seen_q;
	// Fault and comparators merged into one cause; any nonzero source sees it
	assign shutdown_active_o = fault_i && regs_q[6][6:4] != 3'h0;
	// Register file, shutdown status and period timer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			regs_q <= '{default: 8'h00};
			tick_q <= 8'h00;
			seen_q <= 1'b0;
			timer_flag_o <= 1'b0;
		end else begin
			if (dev_we_i)
				regs_q[dev_addr_i] <= dev_data_i;
			// Later assignment wins, so status writes lose while a cause stands
			if (shutdown_active_o) begin
				regs_q[6][7] <= 1'b1;
				seen_q <= 1'b1;
			end else if (seen_q && regs_q[7][7]) begin
				regs_q[6][7] <= 1'b0;
				seen_q <= 1'b0;
			end
			if (regs_q[1][2]) begin
				tick_q <= (tick_q == regs_q[2]) ? 8'h00 : tick_q + 8'h01;
				if (tick_q == regs_q[2])
					timer_flag_o <= 1'b1;
			end
			if (flag_clr_i)
				timer_flag_o <= 1'b0;
		end
	end
endmodule : pwm_dev_model

// file: dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] dat_w = 32'h0000_0000;
	logic [31:0] dat_r;
	logic [31:0] q;
	logic        ack, dev_we, flag_clr, flag, sd_act;
	logic        fault = 1'b0;
	logic [2:0]  dev_addr;
	logic [7:0]  dev_data;
	logic [3:0]  pin_oe;
	logic [7:0]  exp_r [8];
	int          n_errors = 0;
	int          total_checks = 0;
	// 50 MHz clock
	always #10 clk_i = ~clk_i;
	pwm_host pwm_host_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc),
		.we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat_w), .dat_o(dat_r),
		.ack_o(ack), .dev_we_o(dev_we), .dev_addr_o(dev_addr),
		.dev_data_o(dev_data), .timer_flag_clr_o(flag_clr),
		.timer_flag_i(flag), .shutdown_active_i(sd_act),
		.pin_output_en_o(pin_oe));
	pwm_dev_model dev_model_i (.clk_i(clk_i), .rst_i(rst_i), .dev_we_i(dev_we),
		.dev_addr_i(dev_addr), .dev_data_i(dev_data), .flag_clr_i(flag_clr),
		.fault_i(fault), .timer_flag_o(flag), .shutdown_active_o(sd_act));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Classic cycle; entered just after an edge, held until ack is seen
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 50)
			n_errors++;
		q = dat_r;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic reset_dut();
		rst_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask : reset_dut
	// Run setup, poll done, then compare the device register image
	task automatic run(input logic [31:0] c0, input logic [31:0] c1);
		int n;
		n = 0;
		wb(1'b1, pwm_host_pkg::ADR_CFG0, c0);
		wb(1'b1, pwm_host_pkg::ADR_CFG1, c1);
		wb(1'b1, pwm_host_pkg::ADR_CTRL, 32'h0000_0001);
		repeat (30) @(posedge clk_i);
		chk({28'h0, pin_oe}, {28'h0, {4{!fault}} & pin_oe});
		wb(1'b1, pwm_host_pkg::ADR_CFG0, 32'h0000_0009);
		fault <= 1'b0;
		q = 32'h0000_0000;
		while (q[1] !== 1'b1 && n < 100) begin
			wb(1'b0, pwm_host_pkg::ADR_CTRL, 32'h0000_0000);
			n++;
		end
		chk(q & 32'h0000_0003, 32'h0000_0002);
		chk({28'h0, pin_oe}, 32'h0000_000f);
		for (int i = 0; i < 8; i++)
			chk({24'h0, dev_model_i.regs_q[i]}, {24'h0, exp_r[i]});
	endtask : run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	// Main sequence
	initial begin
		reset_dut();
		chk({28'h0, pin_oe}, 32'h0000_0000);
		wb(1'b0, pwm_host_pkg::ADR_STATUS, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		wb(1'b0, 4'h2, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		$display("test reset and unmapped done");
		fault <= 1'b1;
		exp_r = '{8'h00, 8'h05, 8'h05, 8'h40, 8'h00, 8'had, 8'h46, 8'h95};
		run(32'h4ae6_4005, 32'h0000_02cc);
		wb(1'b1, pwm_host_pkg::ADR_CTRL, 32'h0000_0002);
		chk({28'h0, pin_oe}, 32'h0000_0000);
		$display("test guarded setup done");
		reset_dut();
		exp_r = '{8'h00, 8'h04, 8'h07, 8'h00, 8'h00, 8'h0c, 8'h00, 8'h00};
		run(32'h0000_0007, 32'h0000_0000);
		$display("test plain setup done");
		tally_and_finish();
	end
	// Watchdog
	initial begin
		#400_000;
		n_errors++;
		tally_and_finish();
	end
endmodule : tb_top
bind pwm_host pwm_host_assertions chk_i (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dev_we_o(dev_we_o),
	.dev_addr_o(dev_addr_o), .dev_data_o(dev_data_o),
	.timer_flag_clr_o(timer_flag_clr_o), .timer_flag_i(timer_flag_i),
	.pin_output_en_o(pin_output_en_o));
